// [gpb_pkg.sv]
package gpb_pkg;

    localparam int GPB_NPINS = 9;
    localparam int GPB_AW    = 12;
    localparam int GPB_IW    = GPB_AW - 2;
    localparam int GPB_NIRQ  = 16;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_ZERO  = 10'h0E0;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_ONE   = 10'h0E1;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_TWO   = 10'h0E2;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_THREE = 10'h0E3;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_FOUR  = 10'h0E4;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_FIVE  = 10'h0E5;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_SIX   = 10'h0E6;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_ONE_SEVEN = 10'h0E7;
    localparam logic [GPB_IW-1:0] GPB_IDX_PIN_TWO_ZERO  = 10'h0E8;
    localparam logic [GPB_IW-1:0] GPB_IDX_OUT_DATA      = 10'h0D0;
    localparam logic [GPB_IW-1:0] GPB_IDX_IN_LEVEL      = 10'h0D1;
    localparam logic [GPB_IW-1:0] GPB_IDX_COMB_INT      = 10'h0D2;
    localparam logic [GPB_IW-1:0] GPB_IDX_IR_OPT        = 10'h0D3;
    localparam logic [GPB_IW-1:0] GPB_IDX_INT_STATUS    = 10'h0D4;
    localparam logic [GPB_IW-1:0] GPB_IDX_INT_MASK      = 10'h0D5;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int GPB_BIT_DIR      = 0;
    localparam int GPB_BIT_POL      = 1;
    localparam int GPB_BIT_INTEN    = 2;
    localparam int GPB_BIT_ALT      = 3;
    localparam int GPB_BIT_ALT_HI   = 4;
    localparam int GPB_MAP_LSB      = 4;
    localparam int GPB_BIT_IR_MUX   = 6;
    localparam int GPB_BIT_FILT     = 3;
    localparam int GPB_COMB_MAP_LSB = 4;

    // pin roles
    localparam int GPB_PIN_STEER_A = 0;
    localparam int GPB_PIN_STEER_B = 1;
    localparam int GPB_PIN_WATCHDOG = 2;
    localparam int GPB_PIN_LED      = 3;
    localparam int GPB_PIN_ADDR_DEC = 4;
    localparam int GPB_PIN_WR_STB   = 5;
    localparam int GPB_PIN_JOY_SEL  = 6;
    localparam int GPB_PIN_JOY_WR   = 7;
    localparam int GPB_PIN_DISK_KBD = 8;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and encodings
    localparam logic [7:0] GPB_CFG_RST  = 8'h01;
    localparam logic [3:0] GPB_MAP_OFF  = 4'h0;
    localparam logic [3:0] GPB_MAP_BAD  = 4'h2;
    localparam logic [1:0] GPB_JOY_READ = 2'h1;
    localparam logic [1:0] GPB_JOY_CS   = 2'h2;

    // writable bits per pin register; reserved bits stay zero
    localparam logic [GPB_NPINS-1:0][7:0] GPB_CFG_MASK =
        {8'h1F, 8'h0F, 8'h1F, 8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'hFF};

    localparam int GPB_DEBOUNCE_CYC = 4;

endpackage

// [gpb_pin_sync.sv]
`timescale 1ns/10ps
module gpb_pin_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinIn,
    input  wire logic invert,
    output logic      rawLevel,
    output logic      level
);
    import gpb_pkg::*;

    typedef struct packed {
        logic meta;
        logic sync;
        logic level;
    } gpb_sync_t;

    gpb_sync_t st_ff;
    gpb_sync_t nxt_st;

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.meta  = pinIn;
        nxt_st.sync  = st_ff.meta;
        // polarity applied only after the second flop
        nxt_st.level = st_ff.sync ^ invert; // R2 R19
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign rawLevel = st_ff.sync;
    assign level    = st_ff.level;

endmodule

// [gpb_gpio_bank.sv]
`timescale 1ns/10ps
// Notes on behaviour
// R1: config bit 0 set makes the pin an input, clear makes it output.
// R2: config bit 1 inverts the pin's logical sense.
// R3: config bit 2 lets the pin join the combined interrupt.
// R4: pins 0 and 1 alternate input is steered to the line in bits 7:4.
// R5: map value is the line number; 0000 disables, 0010 is invalid.
// R6: pin 1 config behaves exactly like pin 0 config.
// R7: pin 2 alternate is watchdog output, or infrared receive when ir mux set.
// R8: pin 3 alternate is power LED, or infrared transmit when ir mux set.
// R9: pin 4 alternate is the active-low address decode output.
// R10: pin 5 alternate is the active-low write strobe output.
// R11: pin 6 field bits 4:3: 01 joystick read, 10 joystick select, 00 plain.
// R12: pin 7 alternate is the active-low joystick write strobe.
// R13: pin 8 bit 3 gives the active-low second disk channel buffer enable.
// R14: pin 8 bit 4 carries the keyboard controller port bit.
// R15: software must not set pin 8 bits 3 and 4 together.
// R16: reserved config bits are written zero and read back zero.
// R17: combined interrupt goes to its own mapped line, optional debounce.
// R18: ir mux bit selects serial port pins or infrared alternate pins.
// R19: basic mode drives and reads the pin through the polarity inversion.
module gpb_gpio_bank
#(
    parameter int DEBOUNCE_CYC = gpb_pkg::GPB_DEBOUNCE_CYC
)
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [gpb_pkg::GPB_AW-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [gpb_pkg::GPB_NPINS-1:0] gpioIn,
    output logic      [gpb_pkg::GPB_NPINS-1:0] gpioOut,
    output logic      [gpb_pkg::GPB_NPINS-1:0] gpioOe,
    input  wire logic                         watchdogOut,
    input  wire logic                         powerLed,
    input  wire logic                         serialTxData,
    output logic                              serialRxData,
    output logic                              serialTxPin,
    input  wire logic                         serialRxPin,
    input  wire logic                         addrDecodeN,
    input  wire logic                         writeStrobeN,
    input  wire logic                         joyReadN,
    input  wire logic                         joySelectN,
    input  wire logic                         joyWriteN,
    input  wire logic                         secondDiskBufEnN,
    input  wire logic                         keyboardPortBit,
    output logic      [gpb_pkg::GPB_NIRQ-1:0] irqLines,
    output logic                              irqOut
);
    import gpb_pkg::*;

    typedef struct packed {
        logic [GPB_NPINS-1:0][7:0] cfg;
        logic [GPB_NPINS-1:0]      outData;
        logic [GPB_NPINS-1:0]      intStatus;
        logic [GPB_NPINS-1:0]      intMask;
        logic [GPB_NPINS-1:0]      prevLevel;
        logic [3:0]                combMap;
        logic                      combFilt;
        logic                      combStable;
        logic [7:0]                debCnt;
        logic                      irMux;
        logic [GPB_NPINS-1:0]      gpioOut;
        logic [GPB_NPINS-1:0]      gpioOe;
        logic [GPB_NIRQ-1:0]       irqLines;
        logic                      irqOut;
        logic                      serTx;
        logic                      serRx;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
    } gpb_state_t;

    gpb_state_t st_ff;
    gpb_state_t nxt_st;

    logic [GPB_NPINS-1:0] pinLevel;
    logic [GPB_NPINS-1:0] pinRaw;
    logic                 rxRaw;
    logic [GPB_IW-1:0]    regIdx;
    logic [GPB_IW-1:0]    pinOff;
    logic [3:0]           pinSel;
    logic                 isPinReg;

    assign regIdx   = paddr[GPB_AW-1:2];
    assign pinOff   = regIdx - GPB_IDX_PIN_ONE_ZERO;
    assign pinSel   = pinOff[3:0];
    assign isPinReg = (regIdx >= GPB_IDX_PIN_ONE_ZERO) && (regIdx <= GPB_IDX_PIN_TWO_ZERO);

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchronisers

    for (genvar g = 0; g < GPB_NPINS; g++)
    begin : gSync
        gpb_pin_sync uSync
        (
            .clk      (clk),
            .rst      (rst),
            .pinIn    (gpioIn[g]),
            .invert   (st_ff.cfg[g][GPB_BIT_POL]),
            .rawLevel (pinRaw[g]),
            .level    (pinLevel[g])
        );
    end

    gpb_pin_sync uRxSync
    (
        .clk      (clk),
        .rst      (rst),
        .pinIn    (serialRxPin),
        .invert   (1'b0),
        .rawLevel (rxRaw),
        .level    ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic                 access;
        logic                 done;
        logic                 hit;
        logic [31:0]          rd;
        logic [GPB_NPINS-1:0] enMask;
        logic [GPB_NPINS-1:0] clr;
        logic [GPB_NPINS-1:0] rise;
        logic [3:0]           map;
        logic [7:0]           c;
        logic                 comb;
        logic                 combOut;
        access  = psel && penable;
        done    = access && st_ff.pready;
        hit     = 1'b1;
        rd      = 32'h0000_0000;
        enMask  = '0;
        clr     = '0;
        rise    = '0;
        map     = GPB_MAP_OFF;
        c       = 8'h00;
        comb    = 1'b0;
        combOut = 1'b0;
        nxt_st  = st_ff;

        // register read mux, one wait state before pready
        if (isPinReg)
            rd[7:0] = st_ff.cfg[pinSel]; // R16
        else if (regIdx == GPB_IDX_OUT_DATA)
            rd[GPB_NPINS-1:0] = st_ff.outData;
        else if (regIdx == GPB_IDX_IN_LEVEL)
            rd[GPB_NPINS-1:0] = pinLevel; // R19
        else if (regIdx == GPB_IDX_COMB_INT)
            rd[7:0] = {st_ff.combMap, st_ff.combFilt, 3'h0};
        else if (regIdx == GPB_IDX_IR_OPT)
            rd[GPB_BIT_IR_MUX] = st_ff.irMux;
        else if (regIdx == GPB_IDX_INT_STATUS)
            rd[GPB_NPINS-1:0] = st_ff.intStatus;
        else if (regIdx == GPB_IDX_INT_MASK)
            rd[GPB_NPINS-1:0] = st_ff.intMask;
        else
            hit = 1'b0;

        nxt_st.pready = access && !st_ff.pready;
        if (access && !st_ff.pready)
        begin
            nxt_st.prdata  = pwrite ? 32'h0000_0000 : rd;
            nxt_st.pslverr = !hit || (paddr[1:0] != 2'h0);
        end
        else
        begin
            nxt_st.pslverr = 1'b0;
        end

        // writes land on the edge that samples pready high
        if (done && pwrite && hit && (paddr[1:0] == 2'h0))
        begin
            if (isPinReg)
                nxt_st.cfg[pinSel] = pwdata[7:0] & GPB_CFG_MASK[pinSel]; // R16
            else if (regIdx == GPB_IDX_OUT_DATA)
                nxt_st.outData = pwdata[GPB_NPINS-1:0];
            else if (regIdx == GPB_IDX_COMB_INT)
            begin
                nxt_st.combMap  = pwdata[GPB_COMB_MAP_LSB +: 4];
                nxt_st.combFilt = pwdata[GPB_BIT_FILT];
            end
            else if (regIdx == GPB_IDX_IR_OPT)
                nxt_st.irMux = pwdata[GPB_BIT_IR_MUX];
            else if (regIdx == GPB_IDX_INT_STATUS)
                clr = pwdata[GPB_NPINS-1:0];
            else if (regIdx == GPB_IDX_INT_MASK)
                nxt_st.intMask = pwdata[GPB_NPINS-1:0];
        end

        // pin drive, basic mode first, then alternate overrides
        for (int k = 0; k < GPB_NPINS; k++)
        begin
            c = st_ff.cfg[k];
            enMask[k] = c[GPB_BIT_INTEN];
            nxt_st.gpioOe[k]  = !c[GPB_BIT_DIR]; // R1
            nxt_st.gpioOut[k] = st_ff.outData[k] ^ c[GPB_BIT_POL]; // R2 R19
            if (k == GPB_PIN_WATCHDOG && c[GPB_BIT_ALT])
            begin
                // in ir mode the pin only listens
                nxt_st.gpioOe[k]  = !st_ff.irMux; // R7
                nxt_st.gpioOut[k] = watchdogOut; // R7
            end
            else if (k == GPB_PIN_LED && c[GPB_BIT_ALT])
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = st_ff.irMux ? serialTxData : powerLed; // R8 R18
            end
            else if (k == GPB_PIN_ADDR_DEC && c[GPB_BIT_ALT])
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = addrDecodeN; // R9
            end
            else if (k == GPB_PIN_WR_STB && c[GPB_BIT_ALT])
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = writeStrobeN; // R10
            end
            else if (k == GPB_PIN_JOY_SEL && c[GPB_BIT_ALT_HI:GPB_BIT_ALT] == GPB_JOY_READ)
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = joyReadN; // R11
            end
            else if (k == GPB_PIN_JOY_SEL && c[GPB_BIT_ALT_HI:GPB_BIT_ALT] == GPB_JOY_CS)
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = joySelectN; // R11
            end
            else if (k == GPB_PIN_JOY_WR && c[GPB_BIT_ALT])
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = joyWriteN; // R12
            end
            else if (k == GPB_PIN_DISK_KBD && c[GPB_BIT_ALT])
            begin
                // buffer enable wins if software sets both
                nxt_st.gpioOe[k]  = 1'b1; // R15
                nxt_st.gpioOut[k] = secondDiskBufEnN; // R13
            end
            else if (k == GPB_PIN_DISK_KBD && c[GPB_BIT_ALT_HI])
            begin
                nxt_st.gpioOe[k]  = 1'b1;
                nxt_st.gpioOut[k] = keyboardPortBit; // R14
            end
        end

        // steered inputs on pins 0 and 1, identical handling
        nxt_st.irqLines = '0;
        for (int k = GPB_PIN_STEER_A; k <= GPB_PIN_STEER_B; k++)
        begin
            c   = st_ff.cfg[k];
            map = c[GPB_MAP_LSB +: 4];
            if (c[GPB_BIT_ALT] && c[GPB_BIT_DIR] && map != GPB_MAP_OFF && map != GPB_MAP_BAD)
                nxt_st.irqLines[map] = nxt_st.irqLines[map] | pinLevel[k]; // R4 R5 R6
        end

        // combined interrupt with optional debounce
        comb = |(pinLevel & enMask); // R3
        if (comb != st_ff.combStable)
        begin
            nxt_st.debCnt = st_ff.debCnt + 8'h01;
            if (!st_ff.combFilt || st_ff.debCnt >= 8'(DEBOUNCE_CYC - 1))
            begin
                nxt_st.combStable = comb;
                nxt_st.debCnt     = 8'h00;
            end
        end
        else
        begin
            nxt_st.debCnt = 8'h00;
        end
        combOut = st_ff.combFilt ? st_ff.combStable : comb; // R17
        if (st_ff.combMap != GPB_MAP_OFF && st_ff.combMap != GPB_MAP_BAD)
            nxt_st.irqLines[st_ff.combMap] = nxt_st.irqLines[st_ff.combMap] | combOut; // R17 R5

        // sticky rising-edge events; a new event beats the clear
        rise             = pinLevel & ~st_ff.prevLevel & enMask;
        nxt_st.prevLevel = pinLevel;
        nxt_st.intStatus = (st_ff.intStatus & ~clr) | rise;
        nxt_st.irqOut    = |(st_ff.intStatus & st_ff.intMask);

        // serial port pin location
        nxt_st.serTx = st_ff.irMux ? 1'b1 : serialTxData; // R18
        nxt_st.serRx = st_ff.irMux ? pinRaw[GPB_PIN_WATCHDOG] : rxRaw; // R18 R7
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff       <= '0;
            st_ff.cfg   <= {GPB_NPINS{GPB_CFG_RST}};
            st_ff.serTx <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata       = st_ff.prdata;
    assign pready       = st_ff.pready;
    assign pslverr      = st_ff.pslverr;
    assign gpioOut      = st_ff.gpioOut;
    assign gpioOe       = st_ff.gpioOe;
    assign irqLines     = st_ff.irqLines;
    assign irqOut       = st_ff.irqOut;
    assign serialTxPin  = st_ff.serTx;
    assign serialRxData = st_ff.serRx;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_dir_input_oe: assert property (@(posedge clk) disable iff (rst) // R1
        (st_ff.cfg[4][0] && !st_ff.cfg[4][3]) |=> !gpioOe[4])
        else $error("input pin still driven");

    a_out_polarity: assert property (@(posedge clk) disable iff (rst) // R2
        (st_ff.cfg[5][3:0] == 4'h2) |=> (gpioOe[5] && gpioOut[5] == !$past(st_ff.outData[5])))
        else $error("inverted output level wrong");

    a_comb_route: assert property (@(posedge clk) disable iff (rst) // R3
        (st_ff.combMap == 4'h3 && !st_ff.combFilt && st_ff.cfg[7][2] && pinLevel[7]) |=> irqLines[3])
        else $error("combined interrupt not on line 3");

    a_steer_input: assert property (@(posedge clk) disable iff (rst) // R4
        (st_ff.cfg[0] == 8'h59 && pinLevel[0]) |=> irqLines[5])
        else $error("steered input missing on line 5");

    a_map_invalid: assert property (@(posedge clk) disable iff (rst) // R5
        !irqLines[2] && !irqLines[0])
        else $error("invalid or disabled line driven");

    a_pin_one_same: assert property (@(posedge clk) disable iff (rst) // R6
        (st_ff.cfg[1][7:3] == 5'h1F && st_ff.cfg[1][0] && pinLevel[1]) |=> irqLines[15])
        else $error("pin one steering differs");

    a_watchdog_out: assert property (@(posedge clk) disable iff (rst) // R7
        (st_ff.cfg[2][3] && !st_ff.irMux) |=> (gpioOe[2] && gpioOut[2] == $past(watchdogOut)))
        else $error("watchdog not on pin 2");

    a_led_ir_tx: assert property (@(posedge clk) disable iff (rst) // R8
        st_ff.cfg[3][3] |=> (gpioOut[3] == ($past(st_ff.irMux) ? $past(serialTxData) : $past(powerLed))))
        else $error("pin 3 alternate source wrong");

    a_joy_read: assert property (@(posedge clk) disable iff (rst) // R11
        (st_ff.cfg[6][4:3] == 2'h1) |=> (gpioOe[6] && gpioOut[6] == $past(joyReadN)))
        else $error("joystick read strobe missing");

    a_disk_enable: assert property (@(posedge clk) disable iff (rst) // R13
        st_ff.cfg[8][3] |=> (gpioOe[8] && gpioOut[8] == $past(secondDiskBufEnN)))
        else $error("disk buffer enable missing");

    a_kbd_bit: assert property (@(posedge clk) disable iff (rst) // R14
        (st_ff.cfg[8][4:3] == 2'h2) |=> (gpioOut[8] == $past(keyboardPortBit)))
        else $error("keyboard port bit missing");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // R16
        (psel && penable && pready && !pwrite && paddr == 12'h388) |-> (prdata[31:4] == 28'h000_0000))
        else $error("reserved bits read nonzero");

    a_serial_mux: assert property (@(posedge clk) disable iff (rst) // R18
        st_ff.irMux |=> (serialTxPin && serialRxData == $past(pinRaw[2])))
        else $error("serial pins not released in ir mode");

    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        (|(st_ff.intStatus & st_ff.intMask)) |=> ##[0:1] irqOut)
        else $error("interrupt output not raised");

endmodule

// [gpb_pin_partner.sv]
`timescale 1ns/10ps
module gpb_pin_partner
(
    input  wire logic [gpb_pkg::GPB_NPINS-1:0] gpioOut,
    input  wire logic [gpb_pkg::GPB_NPINS-1:0] gpioOe,
    input  wire logic [gpb_pkg::GPB_NPINS-1:0] extLevel,
    output logic      [gpb_pkg::GPB_NPINS-1:0] gpioIn
);
    import gpb_pkg::*;
    // a driven pin reads back its own level, an undriven one the outside world
    always_comb
    begin
        for (int i = 0; i < GPB_NPINS; i++)
        begin
            gpioIn[i] = gpioOe[i] ? gpioOut[i] : extLevel[i];
        end
    end
endmodule

// [test_gpio_pin_config_bank.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin fails++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_gpio_pin_config_bank;
    import gpb_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [GPB_AW-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [8:0]        gpioIn, gpioOut, gpioOe;
    logic [8:0]        extLevel = '0;
    logic [9:0]        src = '0;
    logic              serialRxPin = 1'b0;
    logic              serialRxData, serialTxPin, irqOut;
    logic [15:0]       irqLines;
    logic [31:0]       rdData;
    logic              errFlag;
    int                fails = 0;
    int                nCompared = 0;
    int                altPin [9] = '{2, 3, 4, 5, 6, 6, 7, 8, 8};
    logic [7:0]        altCfg [9] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h08, 8'h10, 8'h08, 8'h08, 8'h10};
    int                altSrc [9] = '{0, 1, 3, 4, 5, 6, 7, 8, 9};
    int                stPin [5] = '{0, 1, 0, 1, 0};
    logic [7:0]        stCfg [5] = '{8'h59, 8'hF9, 8'h39, 8'h29, 8'h09};
    logic [15:0]       stExp [5] = '{16'h0020, 16'h8000, 16'h0008, 16'h0000, 16'h0000};

    always #12.5 clk = ~clk;

    gpb_gpio_bank #(.DEBOUNCE_CYC(4)) u_gpb_gpio_bank
    (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .watchdogOut(src[0]), .powerLed(src[1]), .serialTxData(src[2]), .serialRxData(serialRxData),
        .serialTxPin(serialTxPin), .serialRxPin(serialRxPin), .addrDecodeN(src[3]),
        .writeStrobeN(src[4]), .joyReadN(src[5]), .joySelectN(src[6]), .joyWriteN(src[7]),
        .secondDiskBufEnN(src[8]), .keyboardPortBit(src[9]), .irqLines(irqLines), .irqOut(irqOut)
    );

    gpb_pin_partner u_gpb_pin_partner
    (
        .gpioOut(gpioOut), .gpioOe(gpioOe), .extLevel(extLevel), .gpioIn(gpioIn)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one apb transfer; ends an edge after release so the next call never collides
    task automatic apb(input logic wr, input logic [GPB_IW-1:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 10)
            begin
                fails++;
                results();
            end
            @(posedge clk);
        end
        rdData = prdata;
        errFlag = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input int idx, input logic [31:0] wd);
        apb(1'b1, GPB_IW'(idx), wd);
    endtask

    task automatic rd(input int idx, input logic [31:0] exp);
        apb(1'b0, GPB_IW'(idx), 32'h0000_0000);
        `CHK(rdData, exp)
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] wd;
        tick(20);
        rst <= 1'b0;
        tick(1);
        for (int k = 0; k < GPB_NPINS; k++)
        begin
            // pin 8 never gets both alternate bits at once
            wd = (k == 8) ? 32'hFFFF_FFEF : 32'hFFFF_FFFF;
            rd(GPB_IDX_PIN_ONE_ZERO + k, {24'h0, GPB_CFG_RST});
            wr(GPB_IDX_PIN_ONE_ZERO + k, wd);
            rd(GPB_IDX_PIN_ONE_ZERO + k, {24'h0, GPB_CFG_MASK[k] & wd[7:0]});
            wr(GPB_IDX_PIN_ONE_ZERO + k, 32'h0000_0001);
        end
        apb(1'b0, 10'h3FF, 32'h0000_0000);
        `CHK({errFlag, rdData}, 33'h1_0000_0000)
        $display("test registers done");
        wr(GPB_IDX_OUT_DATA, 32'h0000_01FF);
        for (int k = 0; k < GPB_NPINS; k++)
        begin
            wr(GPB_IDX_PIN_ONE_ZERO + k, 32'h0000_0000);
            tick(3);
            `CHK({gpioOe[k], gpioOut[k]}, 2'b11)
            wr(GPB_IDX_PIN_ONE_ZERO + k, 32'h0000_0002);
            extLevel[k] <= 1'b1;
            tick(3);
            `CHK(gpioOut[k], 1'b0)
            wr(GPB_IDX_PIN_ONE_ZERO + k, 32'h0000_0003);
            tick(6);
            `CHK(gpioOe[k], 1'b0)
            // pins below k already see a high outside level, pins above a low one
            rd(GPB_IDX_IN_LEVEL, (32'h0000_0001 << k) - 32'h0000_0001);
            wr(GPB_IDX_PIN_ONE_ZERO + k, 32'h0000_0001);
            tick(6);
            rd(GPB_IDX_IN_LEVEL, (32'h0000_0001 << (k + 1)) - 32'h0000_0001);
        end
        extLevel <= '0;
        $display("test basic io done");
        for (int i = 0; i < 9; i++)
        begin
            wr(GPB_IDX_PIN_ONE_ZERO + altPin[i], {24'h0, altCfg[i]});
            src <= 10'h001 << altSrc[i];
            tick(3);
            `CHK({gpioOe[altPin[i]], gpioOut[altPin[i]]}, 2'b11)
            src <= ~(10'h001 << altSrc[i]);
            tick(3);
            `CHK(gpioOut[altPin[i]], 1'b0)
            wr(GPB_IDX_PIN_ONE_ZERO + altPin[i], 32'h0000_0001);
        end
        wr(GPB_IDX_IR_OPT, 32'h0000_0040);
        wr(GPB_IDX_PIN_ONE_THREE, 32'h0000_0008);
        wr(GPB_IDX_PIN_ONE_TWO, 32'h0000_0008);
        src <= 10'h004;
        extLevel[2] <= 1'b1;
        tick(6);
        `CHK({gpioOut[3], serialTxPin, gpioOe[2], serialRxData}, 4'b1101)
        wr(GPB_IDX_IR_OPT, 32'h0000_0000);
        src <= 10'h000;
        serialRxPin <= 1'b1;
        tick(6);
        `CHK({serialTxPin, serialRxData}, 2'b01)
        wr(GPB_IDX_PIN_ONE_TWO, 32'h0000_0001);
        wr(GPB_IDX_PIN_ONE_THREE, 32'h0000_0001);
        extLevel <= '0;
        $display("test alternate done");
        for (int i = 0; i < 5; i++)
        begin
            wr(GPB_IDX_PIN_ONE_ZERO + stPin[i], {24'h0, stCfg[i]});
            extLevel[stPin[i]] <= 1'b1;
            tick(8);
            `CHK(irqLines, stExp[i])
            extLevel <= '0;
            tick(8);
            `CHK(irqLines, 16'h0000)
            wr(GPB_IDX_PIN_ONE_ZERO + stPin[i], 32'h0000_0001);
        end
        $display("test steering done");
        // combined line 7 with the debounce filter on
        wr(GPB_IDX_COMB_INT, 32'h0000_0078);
        wr(GPB_IDX_INT_MASK, 32'h0000_0010);
        wr(GPB_IDX_PIN_ONE_FOUR, 32'h0000_0005);
        extLevel[4] <= 1'b1;
        tick(2);
        extLevel[4] <= 1'b0;
        tick(10);
        `CHK(irqLines, 16'h0000)
        wr(GPB_IDX_INT_STATUS, 32'h0000_01FF);
        extLevel[4] <= 1'b1;
        tick(14);
        `CHK({irqLines, irqOut}, 17'h0_0101)
        rd(GPB_IDX_INT_STATUS, 32'h0000_0010);
        wr(GPB_IDX_INT_MASK, 32'h0000_0000);
        tick(2);
        `CHK(irqOut, 1'b0)
        wr(GPB_IDX_INT_MASK, 32'h0000_0010);
        wr(GPB_IDX_INT_STATUS, 32'h0000_0010);
        tick(2);
        `CHK(irqOut, 1'b0)
        rd(GPB_IDX_INT_STATUS, 32'h0000_0000);
        wr(GPB_IDX_PIN_ONE_FOUR, 32'h0000_0001);
        tick(12);
        `CHK(irqLines, 16'h0000)
        // unfiltered combined line 3 follows the pin after the synchroniser, with no debounce delay
        wr(GPB_IDX_COMB_INT, 32'h0000_0030);
        wr(GPB_IDX_PIN_ONE_SEVEN, 32'h0000_0005);
        extLevel[7] <= 1'b1;
        tick(6);
        `CHK(irqLines, 16'h0008)
        $display("test interrupts done");
        results();
    end
endmodule
